// ==== core/sph_defs.vh ====
// Constants for the pin-controlled sleep hold block
`ifndef SPH_DEFS_VH
`define SPH_DEFS_VH
`define SPH_CLK_PERIOD_NS 10
`define SPH_RECOVERY_US 1
`define SPH_RECOVERY_CYCLES ((`SPH_RECOVERY_US * 1000) / `SPH_CLK_PERIOD_NS)
`define SPH_CNT_W 10
// Last recovery count, sized to the counter (recovery cycles minus one)
`define SPH_REC_LAST 10'h063
`define SPH_PIN_W 8
`define SPH_HOLD_W 8
`define SPH_ST_RUN 2'h0
`define SPH_ST_SLEEP 2'h1
`define SPH_ST_RECOVER 2'h2
`endif

// ==== core/sph_pin_keeper.v ====
// One bidirectional pin slot with hold latch and frozen output drive
`include "sph_defs.vh"
module sph_pin_keeper (
  input wire clk,
  input wire rst,
  input wire freeze,
  input wire pin_in,
  input wire user_out,
  input wire user_oe,
  output reg pin_out,
  output reg pin_oe,
  output reg pin_level
);
  always @(posedge clk) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pin_level <= 1'b0;
    end else if (!freeze) begin
      pin_out <= user_out;
      pin_oe <= user_oe;
      // Keeper follows the wire: driven level when driving, input level otherwise
      pin_level <= user_oe ? user_out : pin_in;
    end
  end
endmodule

// ==== core/sph_sleep_hold.v ====
// Pin-controlled sleep hold: freezes logic state, outputs and inputs while asleep
`include "sph_defs.vh"
module sph_sleep_hold (
  input wire clk,
  input wire rst,
  input wire sleep_en_a,
  input wire sleep_en_b,
  input wire sleep_pin_a,
  input wire sleep_pin_b,
  input wire [`SPH_PIN_W-1:0] pin_in,
  input wire [`SPH_PIN_W-1:0] user_out,
  input wire [`SPH_PIN_W-1:0] user_oe,
  input wire [`SPH_HOLD_W-1:0] user_state_next,
  output wire [`SPH_PIN_W-1:0] pin_out,
  output wire [`SPH_PIN_W-1:0] pin_oe,
  output reg [`SPH_PIN_W-1:0] core_in,
  output reg [`SPH_HOLD_W-1:0] user_state,
  output reg user_in_a,
  output reg user_in_b,
  output wire asleep,
  output wire inputs_valid
);
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`SPH_CNT_W-1:0] rec_cnt;
  reg [`SPH_CNT_W-1:0] next_rec_cnt;
  wire sleep_req;
  wire freeze;
  wire [`SPH_PIN_W-1:0] keep_level;
  localparam [`SPH_CNT_W-1:0] REC_LAST = `SPH_REC_LAST;

  // Request from enabled pins only
  assign sleep_req = (sleep_en_a & sleep_pin_a) | (sleep_en_b & sleep_pin_b);
  assign freeze = (state == `SPH_ST_SLEEP) | sleep_req;
  assign asleep = (state == `SPH_ST_SLEEP);
  assign inputs_valid = (state == `SPH_ST_RUN);

  always @* begin
    next_state = state;
    next_rec_cnt = rec_cnt;
    case (state)
      `SPH_ST_RUN: begin
        if (sleep_req) begin
          next_state = `SPH_ST_SLEEP;
        end
      end
      `SPH_ST_SLEEP: begin
        if (!sleep_req) begin
          next_state = `SPH_ST_RECOVER;
          next_rec_cnt = {`SPH_CNT_W{1'b0}};
        end
      end
      `SPH_ST_RECOVER: begin
        if (sleep_req) begin
          next_state = `SPH_ST_SLEEP;
        end else if (rec_cnt == REC_LAST) begin
          next_state = `SPH_ST_RUN;
        end else begin
          next_rec_cnt = rec_cnt + 1'b1;
        end
      end
      default: begin
        next_state = `SPH_ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state <= `SPH_ST_RUN;
      rec_cnt <= {`SPH_CNT_W{1'b0}};
    end else begin
      state <= next_state;
      rec_cnt <= next_rec_cnt;
    end
  end

  // Held logic state and blocked inputs; no reinit on wake
  always @(posedge clk) begin
    if (rst) begin
      user_state <= {`SPH_HOLD_W{1'b0}};
      core_in <= {`SPH_PIN_W{1'b0}};
      user_in_a <= 1'b0;
      user_in_b <= 1'b0;
    end else if (!freeze) begin
      user_state <= user_state_next;
      core_in <= keep_level;
      user_in_a <= sleep_en_a ? 1'b0 : sleep_pin_a;
      user_in_b <= sleep_en_b ? 1'b0 : sleep_pin_b;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `SPH_PIN_W; i = i + 1) begin : g_pin
      // Output drive and enable frozen, so high-Z stays high-Z
      sph_pin_keeper u_keep (
        .clk(clk),
        .rst(rst),
        .freeze(freeze),
        .pin_in(pin_in[i]),
        .user_out(user_out[i]),
        .user_oe(user_oe[i]),
        .pin_out(pin_out[i]),
        .pin_oe(pin_oe[i]),
        .pin_level(keep_level[i])
      );
    end
  endgenerate
endmodule

// ==== tb/sph_ctrl_model.sv ====
// Controller model for the sleep pins
module sph_ctrl_model(input wire logic clk, req_a, req_b,
  output var logic sleep_pin_a, sleep_pin_b);
  always @(posedge clk) {sleep_pin_a, sleep_pin_b} <= #1 {req_a, req_b};
endmodule

// ==== tb/sph_props.sv ====
// Checker for the sleep hold block
module sph_props(input wire logic clk, rst, sleep_en_a, sleep_en_b, sleep_pin_a, sleep_pin_b,
  user_in_a, user_in_b, asleep, inputs_valid,
  input wire logic [7:0] user_state_next, pin_out, pin_oe, core_in, user_state);
  wire req = sleep_en_a & sleep_pin_a | sleep_en_b & sleep_pin_b, run = !req && !asleep;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_go_sleep: assert property (req |=> asleep) else $error("awake");
  chk_state_hold: assert property (req |=> $stable(user_state)) else $error("state");
  chk_out_hold: assert property (req |=> $stable({pin_out, pin_oe}))
    else $error("drive");
  chk_in_block: assert property (req |=> $stable(core_in)) else $error("input");
  chk_plain_a: assert property (run && !sleep_en_a |=> user_in_a == $past(sleep_pin_a))
    else $error("pin a");
  chk_pin_b: assert property (sleep_en_b |=> !user_in_b) else $error("pin b");
  chk_wake_time: assert property ($fell(asleep) |-> ##99 !inputs_valid ##1 inputs_valid)
    else $error("wake");
  chk_wake_state: assert property ($fell(asleep) |-> $stable(user_state) ##1
    user_state == $past(user_state_next))
    else $error("resume");
endmodule
bind sph_sleep_hold sph_props i_chk(.*);

// ==== tb/test_sph_sleep_hold.sv ====
// Bench for the sleep hold block
module test_sph_sleep_hold;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, rst = 1, sleep_en_a = 0, sleep_en_b = 1, req_a = 1, req_b = 0;
  logic [7:0] pin_in = 8'h3C, user_out = 8'hA5, user_oe = 8'h0F, user_state_next = 8'h5A;
  wire sleep_pin_a, sleep_pin_b, user_in_a, user_in_b, asleep, inputs_valid;
  wire [7:0] pin_out, pin_oe, core_in, user_state;
  int n_fail = 0, compares = 0;
  always #5 clk = ~clk;
  sph_ctrl_model i_ctl(.*);
  sph_sleep_hold i_dut(.*);
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %0t %h %h", $time, g, e);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_sleep;
    chk({asleep, user_in_a, user_in_b, inputs_valid}, 4'h5);
    req_b = 1;
    cy(3);
    {pin_in, user_out, user_oe, user_state_next} = 32'hC35AF0A5;
    cy(5);
    chk({pin_out, pin_oe, user_state, core_in}, 32'hA50F5A35);
    chk({asleep, inputs_valid}, 2'h2);
    req_b = 0;
    cy(3);
    chk({asleep, inputs_valid, user_state}, 10'h0A5);
    cy(98);
    chk({pin_out, pin_oe, core_in}, 24'h5AF053);
    chk(inputs_valid, 0);
    cy(1);
    chk(inputs_valid, 1);
    $display("t_sleep end");
  endtask
  task automatic t_sleep_a;
    sleep_en_a = 1;
    cy(2);
    chk({asleep, inputs_valid, user_in_a}, 3'h5);
    req_a = 0;
    cy(3);
    chk({asleep, user_in_a, user_state}, 10'h0A5);
    $display("t_sleep_a end");
  endtask
  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cy(12);
    rst = 0;
    cy(3);
    t_sleep;
    t_sleep_a;
    give_verdict;
  end
  initial begin
    #3000 n_fail++;
    give_verdict;
  end
endmodule
